// ==== logic_cluster.sv ====
// logic cluster: ten cells, register chain, local routing and control block
// How it works
// - the cluster holds ten cells with chains, shared control, local routing and register chain.
// - each cell register can load the register of the cell below it over the chain.
// - the memory-capable variant offers up to 640 bits of dual-port ram in its tables.
// - each ram cell is 64x1 or 32x2, giving a 64x10 or 32x20 cluster array.
// - the memory-capable variant keeps all plain features and each cell is logic or ram.
// - local lines are fed by fabric routing, own cell outputs and left/right direct links.
// - the cluster drives thirty cells: its own ten and ten on each side.
// - control gives three clocks, three enables, two async clears, a sync clear and load.
// - the three cluster clocks come from just two chosen row clock sources.
// - each cluster clock is tied to its own enable for every cell that uses it.
// - using both edges of one source costs two cluster clocks.
// - a low enable stops its cluster clock so its registers see no edge.
// - control is derived from the six row clocks and local routing lines.
// - each register has data, clock, enable, clears and load, or is bypassed.
// - the cluster-wide controls reach the registers in every cell mode.
`timescale 1ns/1ps
module logic_cluster
  import cluster_pkg::*;
#(
  parameter bit MEM_CAPABLE = 1'b1
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [N_ROW_CLK-1:0] row_clk,
  input wire logic [N_ROUTE_IN-1:0] route_in,
  input wire logic [N_CELLS-1:0] left_link_in,
  input wire logic [N_CELLS-1:0] right_link_in,
  input wire logic chain_in,
  input wire ctrl_cfg_t ctrl_cfg,
  input wire cell_cfg_t [N_CELLS-1:0] cell_cfg,
  input wire ram_wr_t ram_wr,
  output logic [N_CELLS-1:0] cell_out_reg,
  output logic [N_CELLS-1:0] aux_out_reg,
  output logic [N_CELLS-1:0] left_link_out_reg,
  output logic [N_CELLS-1:0] right_link_out_reg,
  output logic chain_out_reg,
  output logic [N_CLK-1:0] cluster_clk_tick_reg,
  output logic [CTRL_CNT_W-1:0] ctrl_in_use_reg
);

  logic [N_ROW_CLK-1:0] sync1_reg, sync2_reg, sync3_reg, row_lvl_reg;
  logic [N_SRC-1:0] src_lvl, src_prev_reg, src_rise, src_fall;
  logic [N_CLK-1:0] clk_lvl, clk_edge, clk_idle, en_line, en_hold_reg;
  logic [N_ACLR-1:0] aclr_line;
  logic sclr_line, sload_line;
  logic [N_LOCAL-1:0] local_line;
  logic [N_CELLS-1:0] cell_q, cell_lut, cell_aux, cell_comb, chain_link;
  logic [N_CELLS-1:0] cell_tick, cell_aclr;
  logic [CTRL_CNT_W-1:0] ctrl_in_use_next;

  // out-of-range selects read as a quiet zero
  function automatic logic pick(input logic [N_LOCAL-1:0] l, input logic [SEL_W-1:0] s);
    pick = (int'(s) < N_LOCAL) ? l[s] : 1'h0;
  endfunction

  // own outputs are fed back from their flops so routing cannot form a loop
  assign local_line = {right_link_in, left_link_in, cell_out_reg, route_in};

  // row clocks are pins: three flops, accept a level when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      row_lvl_reg <= '0;
    end else begin
      sync1_reg <= row_clk;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      row_lvl_reg <= (sync2_reg == sync3_reg) ? sync3_reg : row_lvl_reg;
    end
  end

  // only two distinct sources per cluster; bad row index gives a still clock
  always_comb begin
    for (int s = 0; s < N_SRC; s++) begin
      src_lvl[s] = (int'(ctrl_cfg.row_sel[s]) < N_ROW_CLK) ?
                   row_lvl_reg[ctrl_cfg.row_sel[s]] : 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_prev_reg <= '0;
    end else begin
      src_prev_reg <= src_lvl;
    end
  end

  assign src_rise = src_lvl & ~src_prev_reg;
  assign src_fall = ~src_lvl & src_prev_reg;

  // clock enables and the clear/load lines come off local routing
  always_comb begin
    for (int k = 0; k < N_CLK; k++) begin
      clk_lvl[k] = src_lvl[ctrl_cfg.clk[k].src];
      clk_edge[k] = ctrl_cfg.clk[k].fall_edge ? src_fall[ctrl_cfg.clk[k].src] :
                    src_rise[ctrl_cfg.clk[k].src];
      clk_idle[k] = ctrl_cfg.clk[k].fall_edge ? clk_lvl[k] : ~clk_lvl[k];
      en_line[k] = pick(local_line, ctrl_cfg.clk[k].en_sel);
    end
    for (int a = 0; a < N_ACLR; a++) begin
      aclr_line[a] = pick(local_line, ctrl_cfg.aclr_sel[a]);
    end
    sclr_line = pick(local_line, ctrl_cfg.sclr_sel);
    sload_line = pick(local_line, ctrl_cfg.sload_sel);
  end

  // enable may change only in the idle phase, the latch-while-low idea in
  // synchronous form: a clock is never cut or restarted mid pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_hold_reg <= '0;
    end else begin
      for (int k = 0; k < N_CLK; k++) begin
        if (clk_idle[k]) begin
          en_hold_reg[k] <= en_line[k];
        end
      end
    end
  end

  // gated cluster clock: one tick per active edge while its own enable holds
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cluster_clk_tick_reg <= '0;
    end else begin
      cluster_clk_tick_reg <= clk_edge & en_hold_reg;
    end
  end

  // ten cells, each a register chain link to the next
  generate
    for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
      logic [LUT_IN-1:0] lut_in;
      logic [1:0] wdata;
      for (genvar j = 0; j < LUT_IN; j++) begin : g_in
        assign lut_in[j] = pick(local_line, cell_cfg[i].data_sel[j]);
      end
      // a cell can use only its clock's paired enable, never another one
      assign cell_tick[i] = (cell_cfg[i].clk_sel == CLK_NONE) ? 1'h0 :
                            cluster_clk_tick_reg[cell_cfg[i].clk_sel];
      assign cell_aclr[i] = cell_cfg[i].use_aclr & aclr_line[cell_cfg[i].aclr_sel];
      // 64x10 takes one data bit per cell, 32x20 takes two; logic cells always take one
      assign wdata = (MEM_CAPABLE && cell_cfg[i].mode == MODE_RAM && ctrl_cfg.shape == RAM_X2) ?
                     ram_wr.data[2*i+1:2*i] : {1'h0, ram_wr.data[i]};
      assign chain_link[i] = (i == 0) ? chain_in : cell_q[(i == 0) ? 0 : i-1];
      logic_cell u_cell (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cfg(cell_cfg[i]),
        .ram_en(MEM_CAPABLE),
        .shape(ctrl_cfg.shape),
        .lut_in(lut_in),
        .wr_en(ram_wr.en),
        .wr_addr(ram_wr.addr),
        .wr_data(wdata),
        .tick(cell_tick[i]),
        .aclr(cell_aclr[i]),
        .sclr(cell_cfg[i].use_sclr & sclr_line),
        .sload(cell_cfg[i].use_sload & sload_line),
        .chain_in(chain_link[i]),
        .q_reg(cell_q[i]),
        .lut_out(cell_lut[i]),
        .aux_out(cell_aux[i]),
        .cell_out(cell_comb[i])
      );
    end
  endgenerate

  // three identical flop sets feed own local lines and both neighbours: thirty cells
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cell_out_reg <= '0;
      aux_out_reg <= '0;
      left_link_out_reg <= '0;
      right_link_out_reg <= '0;
      chain_out_reg <= 1'h0;
    end else begin
      cell_out_reg <= cell_comb;
      aux_out_reg <= cell_aux;
      left_link_out_reg <= cell_comb;
      right_link_out_reg <= cell_comb;
      chain_out_reg <= cell_q[N_CELLS-1];
    end
  end

  // count controls in use; a used clock always drags its enable along
  always_comb begin
    logic [N_CLK-1:0] clk_used;
    logic [N_ACLR-1:0] aclr_used;
    logic sclr_used;
    logic sload_used;
    int sum;
    clk_used = '0;
    aclr_used = '0;
    sclr_used = 1'h0;
    sload_used = 1'h0;
    sum = 0;
    for (int i = 0; i < N_CELLS; i++) begin
      if (cell_cfg[i].clk_sel != CLK_NONE) begin
        clk_used[cell_cfg[i].clk_sel] = 1'h1;
      end
      if (cell_cfg[i].use_aclr) begin
        aclr_used[cell_cfg[i].aclr_sel] = 1'h1;
      end
      sclr_used = sclr_used | cell_cfg[i].use_sclr;
      sload_used = sload_used | cell_cfg[i].use_sload;
    end
    for (int k = 0; k < N_CLK; k++) begin
      sum = sum + 2 * int'(clk_used[k]);
    end
    for (int a = 0; a < N_ACLR; a++) begin
      sum = sum + int'(aclr_used[a]);
    end
    sum = sum + int'(sclr_used) + int'(sload_used);
    ctrl_in_use_next = sum[CTRL_CNT_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_in_use_reg <= '0;
    end else begin
      ctrl_in_use_reg <= ctrl_in_use_next;
    end
  end

  // checks
  property p_ctrl_limit;
    @(posedge ref_clk) disable iff (!rst_b) ctrl_in_use_reg <= CTRL_CNT_W'(MAX_CTRL);
  endproperty
  a_ctrl_limit: assert property (p_ctrl_limit) else $error("too many controls");

  property p_gate_off;
    @(posedge ref_clk) disable iff (!rst_b) !en_hold_reg[0] |=> !cluster_clk_tick_reg[0];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("tick while disabled");

  property p_gate_steady;
    @(posedge ref_clk) disable iff (!rst_b)
      !clk_idle[0] && $past(!clk_idle[0]) |-> $stable(en_hold_reg[0]);
  endproperty
  a_gate_steady: assert property (p_gate_steady) else $error("enable moved");

  property p_two_edges;
    @(posedge ref_clk) disable iff (!rst_b)
      (ctrl_cfg.clk[0].src == ctrl_cfg.clk[1].src) &&
      (ctrl_cfg.clk[0].fall_edge != ctrl_cfg.clk[1].fall_edge) |->
      !(cluster_clk_tick_reg[0] && cluster_clk_tick_reg[1]);
  endproperty
  a_two_edges: assert property (p_two_edges) else $error("both edges at once");

  property p_row_sync;
    @(posedge ref_clk) disable iff (!rst_b) $rose(row_lvl_reg[0]) |-> $past(row_clk[0], 3);
  endproperty
  a_row_sync: assert property (p_row_sync) else $error("row clock sync");

  property p_chain;
    @(posedge ref_clk) disable iff (!rst_b)
      cell_cfg[1].chain_sel && cell_tick[1] && !cell_aclr[1] &&
      !(cell_cfg[1].use_sclr && sclr_line) && !(cell_cfg[1].use_sload && sload_line)
      |=> cell_q[1] == $past(cell_q[0]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain shift");

  property p_q_cause;
    @(posedge ref_clk) disable iff (!rst_b)
      $changed(cell_q[0]) |-> $past(cell_tick[0] || cell_aclr[0]);
  endproperty
  a_q_cause: assert property (p_q_cause) else $error("register moved untimed");

  property p_aclr;
    @(posedge ref_clk) disable iff (!rst_b) cell_aclr[0] |=> !cell_q[0];
  endproperty
  a_aclr: assert property (p_aclr) else $error("clear ignored");

  property p_fanout;
    @(posedge ref_clk) disable iff (!rst_b)
      (left_link_out_reg == cell_out_reg) && (right_link_out_reg == cell_out_reg);
  endproperty
  a_fanout: assert property (p_fanout) else $error("link mismatch");

  property p_cov_tick;
    @(posedge ref_clk) disable iff (!rst_b) cluster_clk_tick_reg[0] ##[1:20] !en_hold_reg[0];
  endproperty
  c_cov_tick: cover property (p_cov_tick);

  property p_cov_chain;
    @(posedge ref_clk) disable iff (!rst_b) cell_cfg[1].chain_sel && cell_tick[1];
  endproperty
  c_cov_chain: cover property (p_cov_chain);

  property p_cov_wide;
    @(posedge ref_clk) disable iff (!rst_b) ram_wr.en && (ctrl_cfg.shape == RAM_X2);
  endproperty
  c_cov_wide: cover property (p_cov_wide);

endmodule

// ==== cluster_pkg.sv ====
// shared constants and carrier types for the logic cluster model
package cluster_pkg;

  localparam int N_CELLS = 10;
  localparam int N_ROW_CLK = 6;
  localparam int N_CLK = 3;
  localparam int N_SRC = 2;
  localparam int N_ACLR = 2;
  localparam int MAX_CTRL = 10;
  localparam int N_ROUTE_IN = 8;
  localparam int LOC_OWN = N_ROUTE_IN;
  localparam int LOC_LEFT = LOC_OWN + N_CELLS;
  localparam int LOC_RIGHT = LOC_LEFT + N_CELLS;
  localparam int N_LOCAL = LOC_RIGHT + N_CELLS;
  localparam int SEL_W = 6;
  localparam int ROW_SEL_W = 3;
  localparam int LUT_IN = 6;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_DEPTH_X2 = 32;
  localparam int RAM_BITS = N_CELLS * RAM_DEPTH;
  localparam int CLUSTER_FANOUT = 3 * N_CELLS;
  localparam int CTRL_CNT_W = 4;
  localparam logic [1:0] CLK_NONE = 2'h3;
  localparam logic CELL_Q_RESET = 1'h0;

  typedef enum logic {MODE_LOGIC, MODE_RAM} cell_mode_t;
  typedef enum logic {RAM_X1, RAM_X2} ram_shape_t;

  // static per-cell configuration
  typedef struct packed {
    logic [LUT_IN-1:0][SEL_W-1:0] data_sel;
    logic [1:0] clk_sel;
    logic aclr_sel;
    logic use_aclr;
    logic use_sclr;
    logic use_sload;
    logic chain_sel;
    logic registered;
    cell_mode_t mode;
  } cell_cfg_t;

  // one cluster-wide clock: source, edge and paired enable line
  typedef struct packed {
    logic src;
    logic fall_edge;
    logic [SEL_W-1:0] en_sel;
  } clk_cfg_t;

  // static configuration of the shared control block
  typedef struct packed {
    logic [N_SRC-1:0][ROW_SEL_W-1:0] row_sel;
    clk_cfg_t [N_CLK-1:0] clk;
    logic [N_ACLR-1:0][SEL_W-1:0] aclr_sel;
    logic [SEL_W-1:0] sclr_sel;
    logic [SEL_W-1:0] sload_sel;
    ram_shape_t shape;
  } ctrl_cfg_t;

  // shared write port of the lookup tables
  typedef struct packed {
    logic en;
    logic [LUT_IN-1:0] addr;
    logic [2*N_CELLS-1:0] data;
  } ram_wr_t;

endpackage

// ==== logic_cell.sv ====
// one logic cell: lookup table or small dual-port ram plus its register
`timescale 1ns/1ps
module logic_cell
  import cluster_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire cell_cfg_t cfg,
  input wire logic ram_en,
  input wire ram_shape_t shape,
  input wire logic [LUT_IN-1:0] lut_in,
  input wire logic wr_en,
  input wire logic [LUT_IN-1:0] wr_addr,
  input wire logic [1:0] wr_data,
  input wire logic tick,
  input wire logic aclr,
  input wire logic sclr,
  input wire logic sload,
  input wire logic chain_in,
  output logic q_reg,
  output logic lut_out,
  output logic aux_out,
  output logic cell_out
);

  logic [RAM_DEPTH-1:0] mem_reg;
  logic wide;
  logic [LUT_IN-2:0] half_addr;
  logic q_next;

  // wide shape only applies when the cell really runs as ram
  assign wide = ram_en && (cfg.mode == MODE_RAM) && (shape == RAM_X2);
  assign half_addr = wide ? wr_addr[LUT_IN-2:0] : '0;

  // truth table in logic mode, storage in ram mode; same bits either way
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      if (wide) begin
        mem_reg[{half_addr, 1'h0}] <= wr_data[0];
        mem_reg[{half_addr, 1'h1}] <= wr_data[1];
      end else begin
        mem_reg[wr_addr] <= wr_data[0];
      end
    end
  end

  // read port is independent of the write port (simple dual port)
  always_comb begin
    if (wide) begin
      lut_out = mem_reg[{lut_in[LUT_IN-2:0], 1'h0}];
      aux_out = mem_reg[{lut_in[LUT_IN-2:0], 1'h1}];
    end else begin
      lut_out = mem_reg[lut_in];
      aux_out = 1'h0;
    end
  end

  // priority: clear, then synchronous clear, load, chain or table
  always_comb begin
    if (sclr) begin
      q_next = 1'h0;
    end else if (sload) begin
      q_next = lut_in[0];
    end else if (cfg.chain_sel) begin
      q_next = chain_in;
    end else begin
      q_next = lut_out;
    end
  end

  // asynchronous clear lines come from same-clock logic, so they act at the next ref_clk edge without a tick
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= CELL_Q_RESET;
    end else if (aclr) begin
      q_reg <= CELL_Q_RESET;
    end else if (tick) begin
      q_reg <= q_next;
    end
  end

  // combinational functions skip the register
  assign cell_out = cfg.registered ? q_reg : lut_out;

endmodule

// ==== fabric_model.sv ====
// fabric and neighbour model driving row clocks, routing lines and direct links
`timescale 1ns/1ps
module fabric_model
  import cluster_pkg::*;
(
  input wire logic ref_clk,
  output logic [N_ROW_CLK-1:0] row_clk,
  output logic [N_ROUTE_IN-1:0] route_in,
  output logic [N_CELLS-1:0] left_link_in,
  output logic [N_CELLS-1:0] right_link_in,
  output logic chain_in
);
  // everything rests low until a scenario asks for traffic
  initial begin
    row_clk = '0;
    route_in = '0;
    left_link_in = '0;
    right_link_in = '0;
    chain_in = 1'h0;
  end

  // level lines change at the falling edge, well away from sampling
  task automatic drive(input logic [N_ROUTE_IN-1:0] r, input logic [N_CELLS-1:0] l,
                       input logic [N_CELLS-1:0] rt, input logic c);
    @(negedge ref_clk);
    route_in = r;
    left_link_in = l;
    right_link_in = rt;
    chain_in = c;
  endtask

  // one row clock pulse, three cycles per phase so the synchroniser sees both levels
  task automatic pulse(input int idx);
    @(negedge ref_clk);
    row_clk[idx] = 1'h1;
    repeat (3) @(negedge ref_clk);
    row_clk[idx] = 1'h0;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the logic cluster
`timescale 1ns/1ps
module tb_top
  import cluster_pkg::*;
;
  logic ref_clk;
  logic rst_b;
  logic [N_ROW_CLK-1:0] row_clk;
  logic [N_ROUTE_IN-1:0] route_in;
  logic [N_CELLS-1:0] left_link_in;
  logic [N_CELLS-1:0] right_link_in;
  logic chain_in;
  ctrl_cfg_t ctrl_cfg;
  cell_cfg_t [N_CELLS-1:0] cell_cfg;
  ram_wr_t ram_wr;
  logic [N_CELLS-1:0] cell_out_reg;
  logic [N_CELLS-1:0] aux_out_reg;
  logic [N_CELLS-1:0] left_link_out_reg;
  logic [N_CELLS-1:0] right_link_out_reg;
  logic chain_out_reg;
  logic [N_CLK-1:0] cluster_clk_tick_reg;
  logic [CTRL_CNT_W-1:0] ctrl_in_use_reg;
  int mismatches;
  int compares;
  int ticks [N_CLK];

  logic_cluster #(.MEM_CAPABLE(1'h1)) logic_cluster_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .row_clk(row_clk), .route_in(route_in),
    .left_link_in(left_link_in), .right_link_in(right_link_in), .chain_in(chain_in),
    .ctrl_cfg(ctrl_cfg), .cell_cfg(cell_cfg), .ram_wr(ram_wr),
    .cell_out_reg(cell_out_reg), .aux_out_reg(aux_out_reg),
    .left_link_out_reg(left_link_out_reg), .right_link_out_reg(right_link_out_reg),
    .chain_out_reg(chain_out_reg), .cluster_clk_tick_reg(cluster_clk_tick_reg),
    .ctrl_in_use_reg(ctrl_in_use_reg)
  );

  fabric_model fabric_model_i (
    .ref_clk(ref_clk), .row_clk(row_clk), .route_in(route_in),
    .left_link_in(left_link_in), .right_link_in(right_link_in), .chain_in(chain_in)
  );

  // 250 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  // tick pulses last one cycle, so they are summed at every falling edge
  always @(negedge ref_clk) begin
    for (int k = 0; k < N_CLK; k++) ticks[k] += cluster_clk_tick_reg[k];
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // all cells alike; table address taken from the left direct links
  task automatic cells(input cell_mode_t m, input logic rg, input logic ch,
                       input logic [1:0] ck, input logic ac);
    @(negedge ref_clk);
    cell_cfg = '0;
    for (int i = 0; i < N_CELLS; i++) begin
      for (int j = 0; j < LUT_IN; j++) cell_cfg[i].data_sel[j] = SEL_W'(LOC_LEFT + j);
      cell_cfg[i].clk_sel = ck;
      cell_cfg[i].use_aclr = ac;
      cell_cfg[i].chain_sel = ch;
      cell_cfg[i].registered = rg;
      cell_cfg[i].mode = m;
    end
  endtask

  // write held one edge; back-to-back calls keep the strobe high
  task automatic wr(input logic [LUT_IN-1:0] a, input logic [2*N_CELLS-1:0] d);
    @(negedge ref_clk);
    ram_wr = '{1'h1, a, d};
  endtask

  task automatic wr_end();
    @(negedge ref_clk);
    ram_wr.en = 1'h0;
  endtask

  function automatic logic [N_CELLS-1:0] pick(input logic [2*N_CELLS-1:0] d, input int o);
    for (int i = 0; i < N_CELLS; i++) pick[i] = d[2*i+o];
  endfunction

  // single-bit ram: both address ends, links mirror the outputs
  task automatic t_ram_x1();
    logic [LUT_IN-1:0] a [3] = '{6'h00, 6'h3F, 6'h15};
    logic [2*N_CELLS-1:0] d [3] = '{20'h002A5, 20'hFFD5A, 20'h00318};
    cells(MODE_RAM, 1'h0, 1'h0, CLK_NONE, 1'h0);
    ctrl_cfg.shape = RAM_X1;
    for (int k = 0; k < 3; k++) wr(a[k], d[k]);
    wr_end();
    for (int k = 0; k < 3; k++) begin
      fabric_model_i.drive('0, N_CELLS'(a[k]), '0, 1'h0);
      repeat (3) @(negedge ref_clk);
      check("x1 data", cell_out_reg, d[k][N_CELLS-1:0]);
      check("x1 aux", aux_out_reg, 32'h0);
      check("left link", left_link_out_reg, d[k][N_CELLS-1:0]);
      check("right link", right_link_out_reg, d[k][N_CELLS-1:0]);
    end
  endtask

  // two-bit ram: the top address bit is ignored, so 0x25 overwrites word 5
  task automatic t_ram_x2();
    cells(MODE_RAM, 1'h0, 1'h0, CLK_NONE, 1'h0);
    ctrl_cfg.shape = RAM_X2;
    wr(6'h05, 20'h9C3A5);
    wr(6'h25, 20'h5A3C6);
    wr(6'h06, 20'hE1B72);
    wr_end();
    fabric_model_i.drive('0, 10'h005, '0, 1'h0);
    repeat (3) @(negedge ref_clk);
    check("x2 low", cell_out_reg, pick(20'h5A3C6, 0));
    check("x2 high", aux_out_reg, pick(20'h5A3C6, 1));
    fabric_model_i.drive('0, 10'h006, '0, 1'h0);
    repeat (3) @(negedge ref_clk);
    check("x2 low", cell_out_reg, pick(20'hE1B72, 0));
    check("x2 high", aux_out_reg, pick(20'hE1B72, 1));
  endtask

  // logic mode tables fed from right link, own output, routing and left link
  task automatic t_link();
    cells(MODE_LOGIC, 1'h0, 1'h0, CLK_NONE, 1'h0);
    for (int i = 0; i < N_CELLS; i++) cell_cfg[i].data_sel = '1;
    cell_cfg[0].data_sel[0] = SEL_W'(LOC_RIGHT + 2);
    cell_cfg[1].data_sel[0] = SEL_W'(LOC_OWN);
    cell_cfg[2].data_sel[0] = 6'h00;
    cell_cfg[3].data_sel[0] = SEL_W'(LOC_LEFT + 9);
    wr(6'h00, 20'h00000);
    wr(6'h01, 20'hFFFFF);
    wr_end();
    fabric_model_i.drive('0, '0, 10'h004, 1'h0);
    repeat (6) @(negedge ref_clk);
    check("right and own", cell_out_reg, 32'h003);
    fabric_model_i.drive(8'h01, '0, '0, 1'h0);
    repeat (6) @(negedge ref_clk);
    check("routing line", cell_out_reg, 32'h004);
    fabric_model_i.drive('0, 10'h200, '0, 1'h0);
    repeat (6) @(negedge ref_clk);
    check("left line", cell_out_reg, 32'h008);
  endtask

  // register chain on clock 0; both edges of source 0 tick; a low enable stops them
  task automatic t_chain();
    logic [N_CELLS-1:0] pat = 10'h2D3;
    cells(MODE_LOGIC, 1'h1, 1'h1, 2'h0, 1'h0);
    for (int k = 0; k < N_CLK; k++) ticks[k] = 0;
    for (int k = 0; k < N_CELLS; k++) begin
      fabric_model_i.drive(8'h80, '0, '0, pat[N_CELLS-1-k]);
      fabric_model_i.pulse(0);
    end
    repeat (8) @(negedge ref_clk);
    check("chain shift", cell_out_reg, pat);
    check("chain out", chain_out_reg, pat[N_CELLS-1]);
    check("rise ticks", ticks[0], N_CELLS);
    check("fall ticks", ticks[1], N_CELLS);
    check("idle source", ticks[2], 0);
    check("ctrl count", ctrl_in_use_reg, 32'h2);
    fabric_model_i.drive(8'h00, '0, '0, 1'h1);
    repeat (2) fabric_model_i.pulse(0);
    repeat (8) @(negedge ref_clk);
    check("gated hold", cell_out_reg, pat);
    check("gated ticks", ticks[0] + ticks[1], 2 * N_CELLS);
  endtask

  // sync load takes table input 0 (left link 0); sync clear beats it but waits for a tick
  task automatic t_sync();
    cells(MODE_LOGIC, 1'h1, 1'h1, 2'h0, 1'h0);
    ctrl_cfg.sload_sel = 6'h05;
    ctrl_cfg.sclr_sel = 6'h03;
    for (int i = 0; i < N_CELLS; i++) begin
      cell_cfg[i].use_sload = 1'h1;
      cell_cfg[i].use_sclr = 1'h1;
    end
    fabric_model_i.drive(8'hA0, 10'h001, '0, 1'h0);
    fabric_model_i.pulse(0);
    repeat (4) @(negedge ref_clk);
    check("sync load", cell_out_reg, 32'h3FF);
    check("ctrl count", ctrl_in_use_reg, 32'h4);
    fabric_model_i.drive(8'hA8, 10'h001, '0, 1'h0);
    repeat (8) @(negedge ref_clk);
    check("sclr waits tick", cell_out_reg, 32'h3FF);
    fabric_model_i.pulse(0);
    repeat (4) @(negedge ref_clk);
    check("sync clear", cell_out_reg, 32'h0);
    fabric_model_i.drive(8'h00, '0, '0, 1'h0);
  endtask

  // async clear from routing line 4 empties the registers with no clock tick
  task automatic t_aclr();
    @(negedge ref_clk);
    for (int i = 0; i < N_CELLS; i++) cell_cfg[i].use_aclr = 1'h1;
    fabric_model_i.drive(8'h10, '0, '0, 1'h1);
    repeat (4) @(negedge ref_clk);
    check("aclr cells", cell_out_reg, 32'h0);
    check("aclr chain", chain_out_reg, 32'h0);
    fabric_model_i.drive(8'h00, '0, '0, 1'h0);
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  // reset, configuration and scenario sequence
  initial begin
    rst_b = 1'h0;
    ram_wr = '0;
    cell_cfg = '0;
    ctrl_cfg = '0;
    ctrl_cfg.row_sel[0] = 3'h0;
    ctrl_cfg.row_sel[1] = 3'h1;
    ctrl_cfg.clk[0] = '{1'h0, 1'h0, 6'h07};
    ctrl_cfg.clk[1] = '{1'h0, 1'h1, 6'h07};
    ctrl_cfg.clk[2] = '{1'h1, 1'h0, 6'h06};
    ctrl_cfg.aclr_sel[0] = 6'h04;
    ctrl_cfg.aclr_sel[1] = 6'h3F;
    ctrl_cfg.sclr_sel = 6'h3F;
    ctrl_cfg.sload_sel = 6'h3F;
    mismatches = 0;
    compares = 0;
    repeat (10) @(negedge ref_clk);
    check("reset out", cell_out_reg, 32'h0);
    check("reset tick", cluster_clk_tick_reg, 32'h0);
    rst_b = 1'h1;
    t_ram_x1();
    t_ram_x2();
    t_link();
    t_sync();
    t_chain();
    t_aclr();
    test_done();
  end
endmodule
